// ### pkg/cmpc_pkg.sv
// Package holding register map, field layout, timing and carrier types of the comparator control.
package cmpc_pkg;

  // Register byte addresses, one aligned 32-bit word each.
  localparam logic [7:0] OFS_MAIN   = 8'h00;
  localparam logic [7:0] OFS_EDGE   = 8'h04;
  localparam logic [7:0] OFS_MINUS  = 8'h08;
  localparam logic [7:0] OFS_PLUS   = 8'h0C;
  localparam logic [7:0] OFS_MIRROR = 8'h10;
  localparam logic [7:0] OFS_FLAG   = 8'h14;

  // Field positions inside the main control register.
  localparam int BIT_ON   = 7;
  localparam int BIT_RES  = 6;
  localparam int BIT_INV  = 4;
  localparam int BIT_FILT = 3;
  localparam int BIT_RSV  = 2;
  localparam int BIT_HYS  = 1;
  localparam int BIT_SYNC = 0;

  // Field positions inside the edge enable register.
  localparam int BIT_RISE = 1;
  localparam int BIT_FALL = 0;

  // Reset values; the reserved bit comes up set.
  localparam logic [7:0] RST_MAIN  = 8'h04;
  localparam logic [1:0] RST_EDGE  = 2'h0;
  localparam logic [2:0] RST_MINUS = 3'h0;
  localparam logic [3:0] RST_PLUS  = 4'h0;

  // Plus select codes that leave the plus input floating.
  localparam logic [3:0] PLUS_FLOAT_LO = 4'h2;
  localparam logic [3:0] PLUS_FLOAT_HI = 4'h7;

  // AXI4-Lite response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Filter hold time and its cycle count, rounded up, at 8 ns per clock.
  localparam int CLK_PERIOD_NS = 8;
  localparam int HOLD_NS       = 20;
  localparam int HOLD_CYC      = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W        = 3;

  // Master to slave signals of the register bus.
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } cmpc_axi_req_t;

  // Slave to master signals of the register bus.
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } cmpc_axi_rsp_t;

  // Controls driven to the analog comparator core.
  typedef struct packed {
    logic       chanEnable;
    logic       inputDeadbandEnable;
    logic [2:0] minusInputSelect;
    logic [3:0] plusInputSelect;
    logic       plusInputFloat;
  } cmpc_ana_t;

endpackage

// ### core/cmpc_regs.sv
// Comparator channel control registers, result path, edge flag and gate timer output.
`timescale 1ns/1ps


module cmpc_regs
  import cmpc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire cmpc_axi_req_t axiReq,
  output cmpc_axi_rsp_t      axiRsp,
  input  wire logic          cmpRaw,
  input  wire logic          gateClkSrc,
  output logic               gateOut,
  output logic               compareEventFlag,
  output logic               resultBit,
  output cmpc_ana_t          anaCtl
);

  // Complete state of the block in one record.
  typedef struct packed {
    logic [7:0]      mainReg;
    logic [1:0]      edgeEn;
    logic [2:0]      minusSel;
    logic [3:0]      plusSel;
    logic            rawS1;
    logic            rawS2;
    logic            gtS1;
    logic            gtS2;
    logic            gtPrev;
    logic            filt;
    logic [HOLD_W-1:0] hold;
    logic            resPrev;
    logic            flag;
    logic            gate;
    logic            awHeld;
    logic [7:0]      awAddr;
    logic            wHeld;
    logic [31:0]     wData;
    logic [3:0]      wStrb;
    logic            awRdy;
    logic            wRdy;
    logic            bValid;
    logic [1:0]      bResp;
    logic            arRdy;
    logic            rValid;
    logic [31:0]     rData;
    logic [1:0]      rResp;
    cmpc_ana_t       ana;
  } cmpc_state_t;

  // Reset image; the bus ready lines come up high so a master need not wait.
  localparam cmpc_state_t ST_RST = '{
    mainReg:  RST_MAIN,
    edgeEn:   RST_EDGE,
    minusSel: RST_MINUS,
    plusSel:  RST_PLUS,
    hold:     '0,
    awAddr:   8'h00,
    wData:    32'h0000_0000,
    wStrb:    4'h0,
    awRdy:    1'b1,
    wRdy:     1'b1,
    bResp:    RESP_OKAY,
    arRdy:    1'b1,
    rData:    32'h0000_0000,
    rResp:    RESP_OKAY,
    ana:      '0,
    default:  1'b0
  };

  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYC);

  cmpc_state_t stQ;
  cmpc_state_t stD;

  // Read data of one register; unmapped offsets are handled by the caller.
  function automatic logic [31:0] readWord(input cmpc_state_t s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      OFS_MAIN: begin
        v[7:0] = s.mainReg;
        v[BIT_RES] = s.filt;
        v[5] = 1'b0;
      end
      OFS_EDGE:   v[1:0] = s.edgeEn;
      OFS_MINUS:  v[2:0] = s.minusSel;
      OFS_PLUS:   v[3:0] = s.plusSel;
      OFS_MIRROR: v[0] = s.filt;
      OFS_FLAG:   v[0] = s.flag;
      default:    v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // True for every offset that holds a register.
  function automatic logic isMapped(input logic [7:0] a);
    logic m;
    m = 1'b0;
    case (a)
      OFS_MAIN, OFS_EDGE, OFS_MINUS, OFS_PLUS, OFS_MIRROR, OFS_FLAG: m = 1'b1;
      default: m = 1'b0;
    endcase
    return m;
  endfunction

  // Next-state logic for the whole block.
  always_comb begin
    logic cmpSample;
    logic polRes;
    logic rise;
    logic fall;
    logic flagSet;
    logic flagClr;
    logic wrDo;
    logic gtFall;
    cmpSample = 1'b0;
    polRes    = 1'b0;
    rise      = 1'b0;
    fall      = 1'b0;
    flagSet   = 1'b0;
    flagClr   = 1'b0;
    wrDo      = 1'b0;
    gtFall    = 1'b0;
    stD       = stQ;

    // Two-stage synchronisers for the raw compare input and the gate clock.
    stD.rawS1 = cmpRaw;
    stD.rawS2 = stQ.rawS1;
    stD.gtS1  = gateClkSrc;
    stD.gtS2  = stQ.gtS1;

    cmpSample = stQ.mainReg[BIT_ON] & stQ.rawS2;

    polRes = cmpSample ^ stQ.mainReg[BIT_INV];

    // The filter only blocks reversals; a first change passes at once, so it adds no delay.
    if (stQ.mainReg[BIT_FILT]) begin
      if (stQ.hold != '0) begin
        stD.hold = stQ.hold - HOLD_W'(1);
      end else if (polRes != stQ.filt) begin
        stD.filt = polRes;
        stD.hold = HOLD_LOAD - HOLD_W'(1);
      end
    end else begin
      stD.filt = polRes;
      stD.hold = '0;
    end

    stD.resPrev = stQ.filt;
    rise = stQ.filt & ~stQ.resPrev;
    fall = ~stQ.filt & stQ.resPrev;
    flagSet = (rise & stQ.edgeEn[BIT_RISE]) | (fall & stQ.edgeEn[BIT_FALL]);

    // Gate clock falling edge seen on the synchronised copy only.
    stD.gtPrev = stQ.gtS2;
    gtFall = stQ.gtPrev & ~stQ.gtS2;
    if (stQ.mainReg[BIT_SYNC]) begin
      if (gtFall) begin
        stD.gate = stQ.filt;
      end
    end else begin
      stD.gate = stQ.filt;
    end

    // Write address channel capture.
    if (axiReq.awvalid && stQ.awRdy) begin
      stD.awHeld = 1'b1;
      stD.awAddr = axiReq.awaddr;
      stD.awRdy  = 1'b0;
    end

    // Write data channel capture, independent of the address.
    if (axiReq.wvalid && stQ.wRdy) begin
      stD.wHeld = 1'b1;
      stD.wData = axiReq.wdata;
      stD.wStrb = axiReq.wstrb;
      stD.wRdy  = 1'b0;
    end

    // Perform the write once both halves are held.
    wrDo = stQ.awHeld & stQ.wHeld & ~stQ.bValid;
    if (wrDo) begin
      stD.awHeld = 1'b0;
      stD.wHeld  = 1'b0;
      stD.bValid = 1'b1;
      stD.bResp  = isMapped(stQ.awAddr) ? RESP_OKAY : RESP_DECERR;
      // Registers are a byte wide, so only lane zero carries data.
      if (stQ.wStrb[0]) begin
        case (stQ.awAddr)
          OFS_MAIN: begin
            stD.mainReg = stQ.wData[7:0];
            stD.mainReg[BIT_RES] = 1'b0;
            stD.mainReg[5] = 1'b0;
          end
          OFS_EDGE:  stD.edgeEn = stQ.wData[1:0];
          OFS_MINUS: stD.minusSel = stQ.wData[2:0];
          OFS_PLUS:  stD.plusSel = stQ.wData[3:0];
          // Writing a one clears the event flag; zeros leave it alone.
          OFS_FLAG:  flagClr = stQ.wData[0];
          default:   flagClr = 1'b0;
        endcase
      end
    end

    // Release the write channels once the response is taken.
    if (stQ.bValid && axiReq.bready) begin
      stD.bValid = 1'b0;
      stD.awRdy  = 1'b1;
      stD.wRdy   = 1'b1;
    end

    stD.flag = flagSet | (stQ.flag & ~flagClr);

    // Read channel: data is sampled at the edge the address is taken.
    if (axiReq.arvalid && stQ.arRdy) begin
      stD.arRdy  = 1'b0;
      stD.rValid = 1'b1;
      stD.rData  = readWord(stQ, axiReq.araddr);
      stD.rResp  = isMapped(axiReq.araddr) ? RESP_OKAY : RESP_DECERR;
    end
    if (stQ.rValid && axiReq.rready) begin
      stD.rValid = 1'b0;
      stD.arRdy  = 1'b1;
    end

    // Analog controls follow the stored registers one cycle later.
    // Enable to analog core.
    stD.ana.chanEnable = stQ.mainReg[BIT_ON];
    stD.ana.inputDeadbandEnable = stQ.mainReg[BIT_HYS];
    stD.ana.minusInputSelect = stQ.minusSel;
    stD.ana.plusInputSelect = stQ.plusSel;
    stD.ana.plusInputFloat = (stQ.plusSel >= PLUS_FLOAT_LO) &&
                             (stQ.plusSel <= PLUS_FLOAT_HI);
  end

  // State register; a disabled channel still clocks so polarity changes can flag.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stQ <= ST_RST;
    end else begin
      stQ <= stD;
    end
  end

  // Outputs straight from the state flip-flops.
  assign axiRsp.awready  = stQ.awRdy;
  assign axiRsp.wready   = stQ.wRdy;
  assign axiRsp.bvalid   = stQ.bValid;
  assign axiRsp.bresp    = stQ.bResp;
  assign axiRsp.arready  = stQ.arRdy;
  assign axiRsp.rvalid   = stQ.rValid;
  assign axiRsp.rdata    = stQ.rData;
  assign axiRsp.rresp    = stQ.rResp;
  assign gateOut          = stQ.gate;
  assign compareEventFlag = stQ.flag;
  assign resultBit        = stQ.filt;
  assign anaCtl           = stQ.ana;

endmodule

// ### tb/cmpc_regs_props.sv
// Port checker for the comparator control block.
`timescale 1ns/1ps
module cmpc_regs_props
  import cmpc_pkg::*;
(
  input wire logic          clk,
  input wire logic          rstn,
  input wire cmpc_axi_req_t axiReq,
  input wire cmpc_axi_rsp_t axiRsp,
  input wire logic          cmpRaw,
  input wire logic          gateClkSrc,
  input wire logic          gateOut,
  input wire logic          compareEventFlag,
  input wire logic          resultBit,
  input wire cmpc_ana_t     anaCtl
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // A read answer just after its address was taken.
  sequence s_rd(logic [7:0] a);
    $rose(axiRsp.rvalid) && $past(axiReq.araddr) == a;
  endsequence
  // The result changed one or two cycles back.
  sequence s_res_moved;
    $past(resultBit) != $past(resultBit, 2) || $past(resultBit, 2) != $past(resultBit, 3);
  endsequence

  property p_main;
    s_rd(OFS_MAIN) |-> axiRsp.rdata[7] == anaCtl.chanEnable && axiRsp.rdata[6] == $past(resultBit)
      && !axiRsp.rdata[5] && axiRsp.rdata[1] == anaCtl.inputDeadbandEnable;
  endproperty
  property p_mirror;
    s_rd(OFS_MIRROR) |-> axiRsp.rdata == {31'h0, $past(resultBit)};
  endproperty
  property p_minus;
    s_rd(OFS_MINUS) |-> axiRsp.rdata == {29'h0, anaCtl.minusInputSelect};
  endproperty
  property p_plus;
    s_rd(OFS_PLUS) |-> axiRsp.rdata == {28'h0, anaCtl.plusInputSelect};
  endproperty
  property p_float;
    anaCtl.plusInputFloat == (anaCtl.plusInputSelect inside {[4'h2:4'h7]});
  endproperty
  // Only a completed register write may clear the sticky flag.
  property p_flag_hold;
    $fell(compareEventFlag) |-> $rose(axiRsp.bvalid);
  endproperty
  property p_flag_cause;
    $rose(compareEventFlag) |-> s_res_moved;
  endproperty
  property p_gate;
    $changed(gateOut) |-> gateOut == $past(resultBit);
  endproperty
  property p_bhold;
    axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp);
  endproperty
  property p_rlat;
    axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid;
  endproperty

  a_main: assert property (p_main) else $error("main readback wrong");
  a_mirror: assert property (p_mirror) else $error("mirror wrong");
  a_minus: assert property (p_minus) else $error("minus select wrong");
  a_plus: assert property (p_plus) else $error("plus select wrong");
  a_float: assert property (p_float) else $error("float decode wrong");
  a_flag_hold: assert property (p_flag_hold) else $error("flag cleared alone");
  a_flag_cause: assert property (p_flag_cause) else $error("flag without edge");
  a_gate: assert property (p_gate) else $error("gate output wrong");
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  a_rlat: assert property (p_rlat) else $error("read answer late");
endmodule

bind cmpc_regs cmpc_regs_props u_props (.clk(clk), .rstn(rstn), .axiReq(axiReq),
  .axiRsp(axiRsp), .cmpRaw(cmpRaw), .gateClkSrc(gateClkSrc), .gateOut(gateOut),
  .compareEventFlag(compareEventFlag), .resultBit(resultBit), .anaCtl(anaCtl));

// ### tb/tb.sv
// Self-checking bench for the comparator control block.
`timescale 1ns/1ps
module tb;
  import cmpc_pkg::*;
  logic          clk;
  logic          rstn;
  cmpc_axi_req_t req;
  cmpc_axi_rsp_t rsp;
  logic          raw;
  logic          gclk;
  logic          gate;
  logic          flag;
  logic          res;
  cmpc_ana_t     ana;
  logic [34:0]   q[$];
  logic [34:0]   got;
  logic          rv;
  logic          output_invert;
  int            errCount;
  int            checkCount;
  int            cyc;
  int            n;

  cmpc_regs uut (.clk(clk), .rstn(rstn), .axiReq(req), .axiRsp(rsp), .cmpRaw(raw),
    .gateClkSrc(gclk), .gateOut(gate), .compareEventFlag(flag), .resultBit(res), .anaCtl(ana));

  // Free running 125 MHz clock.
  initial clk = 1'b0;
  always #4 clk = ~clk;

  task automatic chk(input logic [34:0] s, input logic [34:0] e);
    checkCount++;
    if (s !== e) begin
      errCount++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic conclude();
    $display("errors %0d checks %0d", errCount, checkCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Write: address and data offered together, each dropped once taken.
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    q.push_back({1'b0, r, 32'h0});
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    req.bready <= 1'b0;
    // Let one edge pass so a following call never reassigns bready in this time step.
    @(posedge clk);
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    q.push_back({1'b1, r, d});
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    req.rready <= 1'b0;
    // One idle edge keeps rready from being raised again at the edge that lowered it.
    @(posedge clk);
  endtask

  // Scoreboard pairs each bus answer with the oldest note; also cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      errCount++;
      conclude();
    end
    if (rsp.bvalid && req.bready) begin
      got = q.pop_front();
      chk({1'b0, rsp.bresp, 32'h0}, got);
    end
    if (rsp.rvalid && req.rready) begin
      got = q.pop_front();
      chk({1'b1, rsp.rresp, rsp.rdata}, got);
    end
  end

  initial begin
    req = '0;
    raw = 1'b0;
    gclk = 1'b1;
    rstn = 1'b0;
    errCount = 0;
    checkCount = 0;
    cyc = 0;
    void'($urandom(32'h8b98));
    tick(10);
    rstn <= 1'b1;
    tick(1);
    axr(OFS_MAIN, 32'h0000_0004, RESP_OKAY);
    for (int i = 1; i < 6; i++) axr(8'(4 * i), 32'h0, RESP_OKAY);
    axw(8'h18, 32'h0000_00FF, RESP_DECERR);
    axr(8'h18, 32'h0, RESP_DECERR);
    // Writable bits only; bit 5 and the result bit ignore writes.
    axw(OFS_MAIN, 32'h0000_002F, RESP_OKAY);
    axr(OFS_MAIN, 32'h0000_000F, RESP_OKAY);
    chk({34'h0, ana.inputDeadbandEnable}, 35'h1);
    for (int i = 1; i < 4; i++) begin
      axw(8'(4 * i), 32'hFFFF_FFFF, RESP_OKAY);
      axr(8'(4 * i), 32'((1 << (i + 1)) - 1), RESP_OKAY);
    end
    for (int c = 0; c < 16; c++) begin
      axw(OFS_MINUS, 32'(c), RESP_OKAY);
      axw(OFS_PLUS, 32'(c), RESP_OKAY);
      chk({31'h0, ana.plusInputSelect}, 35'(c));
      chk({34'h0, ana.plusInputFloat}, 35'(c inside {[2:7]}));
      chk({32'h0, ana.minusInputSelect}, 35'(c % 8));
    end
    // Random comparisons under both polarities.
    for (int i = 0; i < 8; i++) begin
      rv = 1'($urandom);
      output_invert = i[0];
      raw <= rv;
      axw(OFS_MAIN, {24'h0, 3'b100, output_invert, 4'h4}, RESP_OKAY);
      tick(4);
      chk({34'h0, res}, {34'h0, rv ^ output_invert});
      chk({34'h0, gate}, {34'h0, rv ^ output_invert});
      chk({34'h0, ana.chanEnable}, 35'h1);
      axr(OFS_MAIN, {24'h0, 1'b1, rv ^ output_invert, 1'b0, output_invert, 4'h4}, RESP_OKAY);
      axr(OFS_MIRROR, {31'h0, rv ^ output_invert}, RESP_OKAY);
    end
    axw(OFS_MAIN, 32'h0000_0084, RESP_OKAY);
    // Every edge enable setting against a rise and a fall.
    for (int e = 0; e < 4; e++) begin
      raw <= 1'b0;
      tick(6);
      axw(OFS_EDGE, 32'(e), RESP_OKAY);
      axw(OFS_FLAG, 32'h1, RESP_OKAY);
      raw <= 1'b1;
      tick(6);
      chk({34'h0, flag}, 35'(e >> 1));
      axw(OFS_FLAG, 32'h1, RESP_OKAY);
      raw <= 1'b0;
      tick(30);
      chk({34'h0, flag}, 35'(e & 1));
      axr(OFS_FLAG, 32'(e & 1), RESP_OKAY);
    end
    // A one-cycle glitch is stretched only with the filter on.
    for (int f = 0; f < 2; f++) begin
      axw(OFS_MAIN, 32'h84 | 32'(f << 3), RESP_OKAY);
      raw <= 1'b1;
      @(posedge clk);
      raw <= 1'b0;
      n = 0;
      while (res !== 1'b1 && n < 10) begin
        @(posedge clk);
        n++;
      end
      tick(2);
      chk({34'h0, res}, 35'(f));
    end
    // Synchronous mode holds the gate output until the gate clock falls.
    axw(OFS_MAIN, 32'h0000_0085, RESP_OKAY);
    raw <= 1'b1;
    tick(10);
    chk({34'h0, gate}, 35'h0);
    gclk <= 1'b0;
    tick(8);
    chk({34'h0, gate}, 35'h1);
    axw(OFS_MAIN, 32'h0000_0004, RESP_OKAY);
    tick(6);
    chk({34'h0, res}, 35'h0);
    conclude();
  end
endmodule
